/* rtl/dfe_front_end.sv */
// disc decoder front end: dpll, sync protection, demod, q-channel, modes
//
// Overview of operation
// - decode at single or double speed
// - speed bits choose crystal rate and speed
// - divided clock 11.2896, or 5.6448 half-rate
// - lock-to-disc bypasses buffer, rate follows disc
// - stop and pause standby modes
// - motor outputs off in stop and reset
// - audio and clock outputs off in standby
// - control, clock, flag pins ignore standby
// - slicer clock x8 with multiplier, slicer bit
// - digital pll, bandwidth and equalization registers
// - off-track flag marks symbols bad
// - coincidence at 588 plus or minus one
// - window of six resets master counter
// - lock on coincidence, lost after 61 frames
// - lock routed to data line or status
// - run length two stretched to three
// - 14-bit words decoded to 8-bit symbols
// - collect 96-bit q word, check last 16
// - good q word drives ready low
`timescale 1ns/100ps
module dfe_front_end #(
	parameter int OUT_FRAME_CYC = dfe_pkg::OUT_FRAME_CYC,
	parameter logic [15:0] NOM_CH_INC = dfe_pkg::NOM_CH_INC
) (
	input  wire logic                 clk,
	input  wire logic                 rst_n,
	input  wire logic [4:0]           reg_addr,
	input  wire logic [7:0]           reg_wdata,
	input  wire logic                 reg_wr,
	input  wire logic                 reg_rd,
	output logic [7:0]                reg_rdata,
	input  wire logic                 hf_sliced,
	input  wire logic                 clock_multiplier_select,
	input  wire logic                 multi_input_1,
	input  wire logic                 servo_offtrack,
	output dfe_pkg::dfe_symbol_t      symbol,
	output logic                      symbol_valid,
	output logic                      pll_lock,
	output logic                      qword_ready_n,
	output logic                      status_pin_oe,
	output logic                      mcu_data_bit,
	output dfe_pkg::dfe_pin_oe_t      pin_oe,
	output logic                      divided_clock_out,
	output logic                      slicer_clock_x8,
	output logic                      frame_buffer_bypass,
	output logic                      output_frame_tick,
	output logic                      speed_double
);
	// -------------------------------------------------------------
	// configuration registers
	// -------------------------------------------------------------
	logic [3:0]  reg_speed;
	logic [1:0]  reg_standby;
	logic [6:0]  reg_ctrl;
	logic [7:0]  pll_bw;
	logic [7:0]  pll_eq;
	logic [3:0]  reg_slicer;
	logic [7:0]  tbl_idx;
	logic [7:0]  tbl_lo;
	logic        tbl_we;
	logic        half_rate;
	logic        in_stop;
	logic        in_pause;
	logic        off_track;

	assign tbl_we    = reg_wr && (reg_addr == dfe_pkg::REG_TBL_HI);
	assign half_rate = reg_speed[dfe_pkg::SPD_HALF];
	assign in_stop   = reg_standby[0];
	assign in_pause  = (reg_standby == dfe_pkg::STBY_PAUSE);

	// register writes
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			reg_speed   <= dfe_pkg::SPEED_RST;
			reg_standby <= 2'h0;
			reg_ctrl    <= dfe_pkg::CTRL_RST;
			pll_bw      <= dfe_pkg::PLL_BW_RST;
			pll_eq      <= dfe_pkg::PLL_EQ_RST;
			reg_slicer  <= dfe_pkg::SLICER_RST;
			tbl_idx     <= 8'h00;
			tbl_lo      <= 8'h00;
		end
		else if (reg_wr)
		begin
			case (reg_addr)
				dfe_pkg::REG_SPEED:   {reg_speed, reg_standby} <= reg_wdata[5:0];
				dfe_pkg::REG_CTRL:    reg_ctrl   <= reg_wdata[6:0];
				dfe_pkg::REG_PLL_BW:  pll_bw     <= reg_wdata;
				dfe_pkg::REG_PLL_EQ:  pll_eq     <= reg_wdata;
				dfe_pkg::REG_SLICER:  reg_slicer <= reg_wdata[3:0];
				dfe_pkg::REG_TBL_IDX: tbl_idx    <= reg_wdata;
				dfe_pkg::REG_TBL_LO:  tbl_lo     <= reg_wdata;
				default: ;
			endcase
		end
	end

	// off-track source: servo with polarity, or multi input 1
	assign off_track = reg_ctrl[dfe_pkg::CTL_V1SEL] ? multi_input_1
		: (servo_offtrack ^ reg_ctrl[dfe_pkg::CTL_FPOL]);

	// -------------------------------------------------------------
	// digital pll regenerating the channel bit clock
	// -------------------------------------------------------------
	logic        hf_q;
	logic        hf_edge;
	logic [15:0] phase;
	logic [15:0] freq;
	logic [15:0] inc;
	logic signed [15:0] ph_err;
	logic signed [15:0] p_corr;
	logic signed [15:0] f_corr;
	logic [15:0] next_phase;
	logic        bit_tick;

	assign hf_edge    = hf_sliced ^ hf_q;
	assign inc        = speed_double ? {freq[14:0], 1'b0} : freq;
	assign ph_err     = $signed(phase ^ 16'h8000);
	assign p_corr     = ph_err >>> pll_bw[3:0];
	assign f_corr     = ph_err >>> pll_eq[3:0];
	assign next_phase = phase + inc - (hf_edge ? p_corr : 16'sh0000);
	assign bit_tick   = phase[15] && !next_phase[15];

	// proportional phase and integral frequency correction on each edge
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			hf_q  <= 1'b0;
			phase <= 16'h0000;
			freq  <= 16'h0000;
		end
		else
		begin
			hf_q  <= hf_sliced;
			phase <= next_phase;
			if (freq == 16'h0000)
				freq <= NOM_CH_INC;
			else if (hf_edge)
				freq <= freq - f_corr;
		end
	end

	// -------------------------------------------------------------
	// channel bit stream with run-length-two correction
	// -------------------------------------------------------------
	logic [26:0] sr;
	logic        edge_in_cell;
	logic [15:0] err_prev;
	logic [15:0] err_cur;
	logic        pending;
	logic        tick_d;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sr           <= '0;
			edge_in_cell <= 1'b0;
			err_prev     <= '0;
			err_cur      <= '0;
			pending      <= 1'b0;
			tick_d       <= 1'b0;
		end
		else
		begin
			tick_d <= bit_tick;
			if (hf_edge)
			begin
				err_prev <= err_cur;
				err_cur  <= ph_err[15] ? 16'(-ph_err) : 16'(ph_err);
			end
			if (bit_tick)
			begin
				edge_in_cell <= hf_edge;
				if (pending)
				begin
					sr      <= {sr[25:0], 1'b1};
					pending <= 1'b0;
				end
				else if (edge_in_cell && sr[1] && !sr[0])
				begin
					if (err_prev > err_cur)
						sr <= {sr[25:3], 4'h9};
					else
					begin
						sr      <= {sr[25:0], 1'b0};
						pending <= 1'b1;
					end
				end
				else
					sr <= {sr[25:0], edge_in_cell};
			end
			else if (hf_edge)
				edge_in_cell <= 1'b1;
		end
	end

	// -------------------------------------------------------------
	// frame sync protection and lock
	// -------------------------------------------------------------
	logic       sync_hit;
	logic       coinc;
	logic       in_win;
	logic [9:0] master_cnt;
	logic [9:0] since_sync;
	logic [5:0] frames_wo;
	logic       frame_wrap;

	assign sync_hit   = tick_d && (sr[23:0] == dfe_pkg::SYNC_PAT);
	assign coinc      = sync_hit && (since_sync >= dfe_pkg::FRAME_LEN - dfe_pkg::COINC_TOL)
		&& (since_sync <= dfe_pkg::FRAME_LEN + dfe_pkg::COINC_TOL);
	assign in_win     = sync_hit && ((master_cnt >= dfe_pkg::FRAME_LEN - 10'd1 - dfe_pkg::WIN_TOL)
		|| (master_cnt < dfe_pkg::WIN_TOL));
	assign frame_wrap = tick_d && (master_cnt == dfe_pkg::FRAME_LEN - 10'd1);

	// master counter resets on coincidence, in-window sync or frame wrap
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			master_cnt <= '0;
			since_sync <= '0;
		end
		else
		begin
			if (coinc || in_win)
				master_cnt <= '0;
			else if (frame_wrap)
				master_cnt <= '0;
			else if (tick_d)
				master_cnt <= master_cnt + 10'd1;
			if (sync_hit)
				since_sync <= 10'd1;
			else if (tick_d && since_sync != 10'h3FF)
				since_sync <= since_sync + 10'd1;
		end
	end

	// lock: set by coincidence, cleared after 61 frames without one
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			frames_wo <= '0;
			pll_lock  <= 1'b0;
		end
		else if (coinc)
		begin
			frames_wo <= '0;
			pll_lock  <= 1'b1;
		end
		else if (frame_wrap)
		begin
			if (frames_wo == dfe_pkg::LOCK_LOSS - 6'd1)
				pll_lock <= 1'b0;
			if (frames_wo != dfe_pkg::LOCK_LOSS)
				frames_wo <= frames_wo + 6'd1;
		end
	end

	// -------------------------------------------------------------
	// symbol framing and demodulation
	// -------------------------------------------------------------
	logic [4:0] sym_ph;
	logic [5:0] sym_idx;
	logic       word_valid;
	logic       sub_s1;

	assign word_valid = tick_d && (sym_ph == dfe_pkg::SYM_LEN - 5'd1)
		&& (sym_idx < dfe_pkg::SYM_COUNT);

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sym_ph  <= '0;
			sym_idx <= dfe_pkg::SYM_COUNT;
		end
		else if (coinc || in_win)
		begin
			sym_ph  <= '0;
			sym_idx <= '0;
		end
		else if (tick_d)
		begin
			if (sym_ph == dfe_pkg::SYM_LEN - 5'd1)
			begin
				sym_ph <= '0;
				if (sym_idx < dfe_pkg::SYM_COUNT)
					sym_idx <= sym_idx + 6'd1;
			end
			else
				sym_ph <= sym_ph + 5'd1;
		end
	end

	dfe_efm_demod u_demod (
		.clk          (clk),
		.rst_n        (rst_n),
		.tbl_we       (tbl_we),
		.tbl_idx      (tbl_idx),
		.tbl_word     ({reg_wdata[5:0], tbl_lo}),
		.word_valid   (word_valid),
		.word         (sr[13:0]),
		.word_is_sub  (sym_idx == 6'd0),
		.off_track    (off_track),
		.symbol       (symbol),
		.symbol_valid (symbol_valid),
		.sub_s1       (sub_s1)
	);

	// -------------------------------------------------------------
	// q-channel collection
	// -------------------------------------------------------------
	typedef enum {DFE_Q_IDLE, DFE_Q_COLLECT} dfe_qstate_t;
	dfe_qstate_t q_state;
	logic [95:0] q_shift;
	logic [95:0] q_word;
	logic        q_done;
	logic        q_ok;
	logic        q_bit_valid;
	logic        q_release;

	assign q_bit_valid = (q_state == DFE_Q_COLLECT) && symbol_valid && symbol.subcode
		&& !sub_s1;
	assign q_release   = reg_rd && (reg_addr == dfe_pkg::REG_QLAST);

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			q_state <= DFE_Q_IDLE;
		else
		begin
			case (q_state)
				DFE_Q_IDLE:    if (sub_s1) q_state <= DFE_Q_COLLECT;
				DFE_Q_COLLECT: if (q_done) q_state <= DFE_Q_IDLE;
				default:       q_state <= DFE_Q_IDLE;
			endcase
		end
	end

	dfe_qcrc u_qcrc (
		.clk       (clk),
		.rst_n     (rst_n),
		.start     (sub_s1),
		.bit_valid (q_bit_valid),
		.bit_in    (symbol.data[dfe_pkg::Q_BIT_POS]),
		.word      (q_shift),
		.done      (q_done),
		.ok        (q_ok)
	);

	// good word latched; ready low wins over a release read
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			q_word        <= '0;
			qword_ready_n <= 1'b1;
		end
		else if (q_done && q_ok)
		begin
			q_word        <= q_shift;
			qword_ready_n <= 1'b0;
		end
		else if (q_release)
			qword_ready_n <= 1'b1;
	end

	// -------------------------------------------------------------
	// clocks, modes and pin enables
	// -------------------------------------------------------------
	logic [23:0] div_acc;
	logic [12:0] out_cnt;
	logic [12:0] out_len;

	assign divided_clock_out = div_acc[23];
	assign out_len = speed_double ? 13'(OUT_FRAME_CYC / 2) : 13'(OUT_FRAME_CYC);

	// divided clock synthesis and output frame rate
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			div_acc           <= '0;
			out_cnt           <= '0;
			output_frame_tick <= 1'b0;
		end
		else
		begin
			div_acc <= div_acc + (half_rate ? dfe_pkg::DIV_INC_HALF
				: dfe_pkg::DIV_INC_FULL);
			if (reg_ctrl[dfe_pkg::CTL_L2D])
			begin
				output_frame_tick <= frame_wrap || coinc || in_win;
				out_cnt           <= '0;
			end
			else if (out_cnt >= out_len - 13'd1)
			begin
				output_frame_tick <= 1'b1;
				out_cnt           <= '0;
			end
			else
			begin
				output_frame_tick <= 1'b0;
				out_cnt           <= out_cnt + 13'd1;
			end
		end
	end

	// mode flags and tri-state enables; reset leaves all pins released
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pin_oe              <= '0;
			speed_double        <= 1'b0;
			slicer_clock_x8     <= 1'b0;
			frame_buffer_bypass <= 1'b0;
		end
		else
		begin
			pin_oe.motor        <= !in_stop;
			pin_oe.audio        <= !in_stop && !in_pause;
			pin_oe.divclk       <= !in_stop && !in_pause;
			speed_double        <= reg_speed[dfe_pkg::SPD_DOUBLE];
			slicer_clock_x8     <= clock_multiplier_select && !reg_slicer[3];
			frame_buffer_bypass <= reg_ctrl[dfe_pkg::CTL_L2D];
		end
	end

	// status routing; unaffected by standby
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			status_pin_oe <= 1'b0;
			mcu_data_bit  <= 1'b1;
		end
		else
		begin
			case (reg_ctrl[4:3])
				dfe_pkg::ROUTE_LOCK: status_pin_oe <= !pll_lock;
				dfe_pkg::ROUTE_QRDY: status_pin_oe <= !qword_ready_n;
				default:             status_pin_oe <= 1'b0;
			endcase
			case (reg_ctrl[6:5])
				dfe_pkg::ROUTE_LOCK: mcu_data_bit <= pll_lock;
				dfe_pkg::ROUTE_QRDY: mcu_data_bit <= qword_ready_n;
				default:             mcu_data_bit <= 1'b1;
			endcase
		end
	end

	// register reads, data one cycle after the strobe
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			reg_rdata <= 8'h00;
		else if (reg_rd)
		begin
			if (reg_addr >= dfe_pkg::REG_QWORD && reg_addr <= dfe_pkg::REG_QLAST)
				reg_rdata <= q_word[8'(8'd95 - 8'({reg_addr - dfe_pkg::REG_QWORD, 3'b000})) -: 8];
			else
			begin
				case (reg_addr)
					dfe_pkg::REG_SPEED:   reg_rdata <= {2'b00, reg_speed, reg_standby};
					dfe_pkg::REG_CTRL:    reg_rdata <= {1'b0, reg_ctrl};
					dfe_pkg::REG_PLL_BW:  reg_rdata <= pll_bw;
					dfe_pkg::REG_PLL_EQ:  reg_rdata <= pll_eq;
					dfe_pkg::REG_SLICER:  reg_rdata <= {4'h0, reg_slicer};
					dfe_pkg::REG_STATUS:  reg_rdata <= {4'h0, half_rate, slicer_clock_x8,
						qword_ready_n, pll_lock};
					dfe_pkg::REG_TBL_IDX: reg_rdata <= tbl_idx;
					default:              reg_rdata <= 8'h00;
				endcase
			end
		end
		else
			reg_rdata <= 8'h00;
	end
endmodule

/* rtl/dfe_pkg.sv */
// shared constants and types for the disc decoder front end
package dfe_pkg;

	// -------------------------------------------------------------
	// timing
	// -------------------------------------------------------------
	localparam longint CLK_HZ         = 40000000;
	localparam longint DIVCLK_FULL_HZ = 11289600;
	localparam longint DIVCLK_HALF_HZ = 5644800;
	localparam longint FRAME_RATE_HZ  = 7350;
	localparam logic [23:0] DIV_INC_FULL = 24'((DIVCLK_FULL_HZ << 24) / CLK_HZ);
	localparam logic [23:0] DIV_INC_HALF = 24'((DIVCLK_HALF_HZ << 24) / CLK_HZ);
	localparam int OUT_FRAME_CYC = int'(CLK_HZ / FRAME_RATE_HZ);
	localparam logic [15:0] NOM_CH_INC = 16'h1BA9; // channel rate at n = 1

	// -------------------------------------------------------------
	// frame structure
	// -------------------------------------------------------------
	localparam logic [9:0] FRAME_LEN  = 10'd588;
	localparam logic [9:0] COINC_TOL  = 10'd1;
	localparam logic [9:0] WIN_TOL    = 10'd6;
	localparam logic [5:0] LOCK_LOSS  = 6'd61;
	localparam logic [4:0] SYM_LEN    = 5'd17;
	localparam logic [5:0] SYM_COUNT  = 6'd33;
	localparam logic [6:0] Q_BITS     = 7'd96;
	localparam logic [6:0] Q_CRC_BITS = 7'd80;
	localparam logic [15:0] Q_POLY    = 16'h1021;
	localparam logic [23:0] SYNC_PAT  = 24'h801002;
	localparam logic [13:0] SUB_S0    = 14'h0801;
	localparam logic [13:0] SUB_S1    = 14'h0012;
	localparam int Q_BIT_POS = 6;

	// -------------------------------------------------------------
	// register map
	// -------------------------------------------------------------
	localparam logic [4:0] REG_SPEED   = 5'h00;
	localparam logic [4:0] REG_CTRL    = 5'h01;
	localparam logic [4:0] REG_PLL_BW  = 5'h02;
	localparam logic [4:0] REG_PLL_EQ  = 5'h03;
	localparam logic [4:0] REG_SLICER  = 5'h04;
	localparam logic [4:0] REG_STATUS  = 5'h05;
	localparam logic [4:0] REG_TBL_IDX = 5'h06;
	localparam logic [4:0] REG_TBL_LO  = 5'h07;
	localparam logic [4:0] REG_TBL_HI  = 5'h08;
	localparam logic [4:0] REG_QWORD   = 5'h10;
	localparam logic [4:0] REG_QLAST   = 5'h1B;
	localparam logic [3:0] SPEED_RST   = 4'h0;
	localparam logic [6:0] CTRL_RST    = 7'h00;
	localparam logic [7:0] PLL_BW_RST  = 8'h04;
	localparam logic [7:0] PLL_EQ_RST  = 8'h0A;
	localparam logic [3:0] SLICER_RST  = 4'h0;
	localparam int SPD_DOUBLE = 3;
	localparam int SPD_HALF   = 2;
	localparam int CTL_L2D    = 0;
	localparam int CTL_V1SEL  = 1;
	localparam int CTL_FPOL   = 2;
	localparam logic [1:0] STBY_STOP  = 2'h1;
	localparam logic [1:0] STBY_PAUSE = 2'h2;
	localparam logic [1:0] ROUTE_LOCK = 2'h1;
	localparam logic [1:0] ROUTE_QRDY = 2'h2;

	// -------------------------------------------------------------
	// types
	// -------------------------------------------------------------
	typedef struct packed {
		logic [7:0] data;
		logic       err;
		logic       subcode;
	} dfe_symbol_t;

	typedef struct packed {
		logic motor;
		logic audio;
		logic divclk;
	} dfe_pin_oe_t;

endpackage

/* rtl/dfe_efm_demod.sv */
// 14-to-8 channel word demodulator with software-loaded table
`timescale 1ns/100ps
module dfe_efm_demod (
	input  wire logic                 clk,
	input  wire logic                 rst_n,
	input  wire logic                 tbl_we,
	input  wire logic [7:0]           tbl_idx,
	input  wire logic [13:0]          tbl_word,
	input  wire logic                 word_valid,
	input  wire logic [13:0]          word,
	input  wire logic                 word_is_sub,
	input  wire logic                 off_track,
	output dfe_pkg::dfe_symbol_t      symbol,
	output logic                      symbol_valid,
	output logic                      sub_s1
);
	logic [13:0] table_mem [256];
	logic [255:0] entry_ok;
	logic [255:0] hit;
	logic [7:0]   hit_idx;
	logic         hit_any;

	// table load
	always_ff @(posedge clk)
	begin
		if (tbl_we)
			table_mem[tbl_idx] <= tbl_word;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			entry_ok <= '0;
		else if (tbl_we)
			entry_ok[tbl_idx] <= 1'b1;
	end

	// parallel compare of all entries
	genvar g;
	generate
		for (g = 0; g < 256; g++)
		begin : g_cmp
			assign hit[g] = entry_ok[g] && (table_mem[g] == word);
		end
	endgenerate

	always_comb
	begin
		hit_idx = 8'h00;
		hit_any = 1'b0;
		for (int i = 255; i >= 0; i--)
		begin
			if (hit[i])
			begin
				hit_idx = 8'(i);
				hit_any = 1'b1;
			end
		end
	end

	// registered symbol; miss or off-track marks it bad
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			symbol       <= '0;
			symbol_valid <= 1'b0;
			sub_s1       <= 1'b0;
		end
		else
		begin
			symbol_valid <= word_valid;
			sub_s1       <= word_valid && word_is_sub && (word == dfe_pkg::SUB_S1);
			if (word_valid)
			begin
				symbol.data    <= hit_idx;
				symbol.err     <= ~hit_any || off_track;
				symbol.subcode <= word_is_sub;
			end
		end
	end
endmodule

/* rtl/dfe_qcrc.sv */
// q-channel word collector and checker
`timescale 1ns/100ps
module dfe_qcrc (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        start,
	input  wire logic        bit_valid,
	input  wire logic        bit_in,
	output logic [95:0]      word,
	output logic             done,
	output logic             ok
);
	logic [15:0] crc;
	logic [6:0]  cnt;
	logic        fb;

	assign fb = crc[15] ^ bit_in;

	// shift in 96 bits, crc over the first 80
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			crc  <= '0;
			cnt  <= '0;
			word <= '0;
			done <= 1'b0;
			ok   <= 1'b0;
		end
		else
		begin
			done <= 1'b0;
			if (start)
			begin
				crc <= '0;
				cnt <= '0;
			end
			else if (bit_valid && cnt < dfe_pkg::Q_BITS)
			begin
				word <= {word[94:0], bit_in};
				cnt  <= cnt + 7'd1;
				if (cnt < dfe_pkg::Q_CRC_BITS)
					crc <= {crc[14:0], 1'b0} ^ (fb ? dfe_pkg::Q_POLY : 16'h0000);
				if (cnt == dfe_pkg::Q_BITS - 7'd1)
				begin
					done <= 1'b1;
					ok   <= (crc == ~{word[14:0], bit_in});
				end
			end
		end
	end
endmodule

/* verification/dfe_disc_model.sv */
// disc read channel model: framed nrzi channel bits
`timescale 1ns/100ps
module dfe_disc_model #(
	parameter logic [15:0]	INC = 16'h8000
) (
	input wire logic	clk,
	input wire logic	rst_n,
	input wire logic	sync_en,
	output logic	hf_sliced
);
	logic [16:0]	acc;
	logic [9:0]	pos;
	logic [9:0]	k;
	logic	bit_now;
	// channel bit of the frame position; filler replaces the sync when it is off
	always_comb
	begin
		k = (pos - 10'h1B) % 10'h11;
		if (pos < 10'h18)
			bit_now = sync_en ? dfe_pkg::SYNC_PAT[5'(10'h17 - pos)] : (pos % 10'h3 == 10'h1);
		else if (pos < 10'h1B)
			bit_now = 1'b0;
		else
			bit_now = (k < 10'hE) ? 1'(14'h1224 >> (10'hD - k)) : 1'b0;
	end
	// bit cells at nominal disc speed, line toggles on a one
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			acc <= 17'h0;
			pos <= 10'h0;
			hf_sliced <= 1'b0;
		end
		else
		begin
			acc <= {1'b0, acc[15:0]} + {1'b0, INC};
			if (acc[16])
			begin
				pos <= (pos == 10'h24B) ? 10'h0 : pos + 10'h1;
				hf_sliced <= hf_sliced ^ bit_now;
			end
		end
	end
endmodule

/* verification/dfe_front_end_chk.sv */
// port assertions of the disc decoder front end
`timescale 1ns/100ps
module dfe_front_end_chk (
	input wire logic	clk,
	input wire logic	rst_n,
	input wire logic [4:0]	reg_addr,
	input wire logic [7:0]	reg_wdata,
	input wire logic	reg_wr,
	input wire logic	reg_rd,
	input wire logic	symbol_valid,
	input wire logic	qword_ready_n,
	input wire dfe_pkg::dfe_pin_oe_t	pin_oe,
	input wire logic	frame_buffer_bypass,
	input wire logic	output_frame_tick,
	input wire logic	speed_double
);
	localparam logic [4:0]	SPD = dfe_pkg::REG_SPEED;
	localparam logic [4:0]	CTL = dfe_pkg::REG_CTRL;
	logic	rd_ql;
	// read of the last q byte
	assign rd_ql = reg_rd && reg_addr == dfe_pkg::REG_QLAST;
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	// write qualified by v, not overwritten in the next cycle
	sequence wr_of(a, v);
		reg_wr && reg_addr == a && v ##1 !(reg_wr && reg_addr == a);
	endsequence
	a_stop_offline: assert property (wr_of(SPD, reg_wdata[0])
		|=> pin_oe == 3'h0)
		else $error("stop left pins on");
	a_pause_motor: assert property (wr_of(SPD, reg_wdata[1:0] == 2'h2)
		|=> pin_oe == 3'h4)
		else $error("pause pins wrong");
	a_run_drive: assert property (wr_of(SPD, reg_wdata[1:0] == 2'h0)
		|=> pin_oe == 3'h7)
		else $error("run pins off");
	a_speed_pick: assert property (wr_of(SPD, 1'b1)
		|=> speed_double == $past(reg_wdata[5], 2))
		else $error("speed wrong");
	a_bypass_ctl: assert property (wr_of(CTL, 1'b1)
		|=> frame_buffer_bypass == $past(reg_wdata[0], 2))
		else $error("bypass wrong");
	a_qready_release: assert property ($rose(qword_ready_n)
		|-> $past(rd_ql) || $past(rd_ql, 2))
		else $error("ready dropped unread");
	a_tick_gap: assert property (output_frame_tick |=> !output_frame_tick [*8])
		else $error("tick too long");
	a_symbol_gap: assert property (symbol_valid |=> !symbol_valid [*8])
		else $error("symbols too close");
endmodule
bind dfe_front_end dfe_front_end_chk u_chk (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .symbol_valid(symbol_valid),
	.qword_ready_n(qword_ready_n), .pin_oe(pin_oe), .frame_buffer_bypass(frame_buffer_bypass),
	.output_frame_tick(output_frame_tick), .speed_double(speed_double));

/* verification/dfe_front_end_bench.sv */
// self-checking bench of the disc decoder front end
`timescale 1ns/100ps
module dfe_front_end_bench;
	logic	clk = 1'b0;
	logic	rst_n = 1'b0;
	logic [4:0]	reg_addr = 5'h0;
	logic [7:0]	reg_wdata = 8'h0;
	logic	reg_wr = 1'b0;
	logic	reg_rd = 1'b0;
	logic	clock_multiplier_select = 1'b0;
	logic	multi_input_1 = 1'b0;
	logic	servo_offtrack = 1'b0;
	logic	sync_en = 1'b1;
	logic [7:0]	reg_rdata, v;
	logic	hf_sliced, pll_lock, qword_ready_n, mcu_data_bit, divided_clock_out, prev;
	logic	slicer_clock_x8, frame_buffer_bypass, speed_double, symbol_valid, status_pin_oe;
	dfe_pkg::dfe_symbol_t	symbol;
	dfe_pkg::dfe_pin_oe_t	pin_oe;
	int	err_total = 0;
	int	samples_checked = 0;
	int	cyc = 0;
	int	seed = 47;
	int	n;
	// clock and cycle ceiling
	always #12.5 clk = ~clk;
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 90000)
		begin
			err_total++;
			results();
		end
	end
	dfe_disc_model #(.INC(16'h8000)) u_disc (.clk(clk), .rst_n(rst_n), .sync_en(sync_en),
		.hf_sliced(hf_sliced));
	dfe_front_end #(.OUT_FRAME_CYC(64), .NOM_CH_INC(16'h8000)) DUT (.clk(clk), .rst_n(rst_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .hf_sliced(hf_sliced), .multi_input_1(multi_input_1),
		.clock_multiplier_select(clock_multiplier_select), .servo_offtrack(servo_offtrack),
		.symbol(symbol), .symbol_valid(symbol_valid), .pll_lock(pll_lock), .pin_oe(pin_oe),
		.qword_ready_n(qword_ready_n), .status_pin_oe(status_pin_oe),
		.mcu_data_bit(mcu_data_bit),
		.divided_clock_out(divided_clock_out), .slicer_clock_x8(slicer_clock_x8),
		.frame_buffer_bypass(frame_buffer_bypass), .output_frame_tick(), .speed_double(speed_double));
	// expected pin enables and divided clock edges in 800 cycles
	function automatic logic [2:0] oe_for(input logic [1:0] s);
		return s[0] ? 3'h0 : (s[1] ? 3'h4 : 3'h7);
	endfunction
	function automatic int edges_for(input logic half);
		return int'(real'(half ? dfe_pkg::DIVCLK_HALF_HZ : dfe_pkg::DIVCLK_FULL_HZ) * 2.0E-5);
	endfunction
	// compare, bus cycles and symbol wait
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			err_total++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		repeat (2) @(posedge clk);
		@(negedge clk);
	endtask
	task automatic rd(input logic [4:0] a, input logic [7:0] e);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		chk(16'(reg_rdata), 16'(e));
	endtask
	task automatic sym(input int k);
		repeat (k)
			do @(negedge clk); while (symbol_valid !== 1'b1 || symbol.subcode !== 1'b0);
	endtask
	task automatic results();
		if (err_total == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// main sequence
	initial
	begin
		repeat (12) @(negedge clk);
		chk(16'({pin_oe, pll_lock, qword_ready_n}), 16'h1);
		@(posedge clk) rst_n <= 1'b1;
		repeat (2) @(negedge clk);
		chk(16'(pin_oe), 16'h7);
		rd(dfe_pkg::REG_PLL_BW, dfe_pkg::PLL_BW_RST);
		rd(dfe_pkg::REG_PLL_EQ, dfe_pkg::PLL_EQ_RST);
		rd(5'h1F, 8'h0);
		for (int i = 0; i < 6; i++)
		begin
			v = (i < 4) ? 8'(i << 4) : 8'($random(seed)) & 8'h3C;
			wr(dfe_pkg::REG_SPEED, v);
			rd(dfe_pkg::REG_SPEED, v);
			chk(16'(speed_double), 16'(v[5]));
			n = 0;
			repeat (800)
			begin
				@(negedge clk);
				n += int'(divided_clock_out & ~prev);
				prev = divided_clock_out;
			end
			chk(16'(n > edges_for(v[4]) - 3 && n < edges_for(v[4]) + 3), 16'h1);
		end
		for (int i = 1; i < 5; i++)
		begin
			wr(dfe_pkg::REG_SPEED, 8'(i % 4));
			chk(16'(pin_oe), 16'(oe_for(2'(i))));
		end
		@(posedge clk) clock_multiplier_select <= 1'b1; // 8.4672 MHz source
		wr(dfe_pkg::REG_SLICER, 8'h0);
		chk(16'(slicer_clock_x8), 16'h1);
		wr(dfe_pkg::REG_SLICER, 8'h8);
		chk(16'(slicer_clock_x8), 16'h0);
		@(posedge clk) clock_multiplier_select <= 1'b0;
		wr(dfe_pkg::REG_CTRL, 8'h1);
		chk(16'(frame_buffer_bypass), 16'h1);
		wr(dfe_pkg::REG_TBL_IDX, 8'hA5);
		wr(dfe_pkg::REG_TBL_LO, 8'h24);
		wr(dfe_pkg::REG_TBL_HI, 8'h12);
		wr(dfe_pkg::REG_CTRL, 8'h28);
		for (n = 0; n < 20000 && pll_lock !== 1'b1; n++) @(negedge clk);
		@(negedge clk);
		chk(16'({pll_lock, mcu_data_bit, status_pin_oe}), 16'h6);
		rd(dfe_pkg::REG_STATUS, 8'h3);
		sym(2);
		chk(16'({symbol.data, symbol.err}), 16'h14A);
		@(posedge clk) servo_offtrack <= 1'b1;
		sym(2);
		chk(16'(symbol.err), 16'h1);
		@(posedge clk) servo_offtrack <= 1'b0;
		wr(dfe_pkg::REG_CTRL, 8'h24);
		sym(2);
		chk(16'(symbol.err), 16'h1);
		wr(dfe_pkg::REG_CTRL, 8'h22);
		@(posedge clk) multi_input_1 <= 1'b1;
		sym(2);
		chk(16'(symbol.err), 16'h1);
		wr(dfe_pkg::REG_CTRL, 8'h50);
		chk(16'({mcu_data_bit, status_pin_oe}), 16'h2);
		wr(dfe_pkg::REG_CTRL, 8'h28);
		@(posedge clk) sync_en <= 1'b0;
		repeat (59 * 588 * 2) @(negedge clk);
		chk(16'(pll_lock), 16'h1);
		for (n = 0; n < 6000 && pll_lock !== 1'b0; n++) @(negedge clk);
		@(negedge clk);
		chk(16'({pll_lock, mcu_data_bit, status_pin_oe}), 16'h1);
		results();
	end
endmodule
